/* File: rtl/cgp_clock_ctrl.sv */
// Clock generator, power-down sequencer and divider output, AXI4-Lite
//
// Function
// - Generate all chip clocks with gating, selection.
// - Divider with 4-bit ratio follows source selection.
// - Power-down needs control bit then core sleep.
// - Power-down stops fast oscillators and their clocks.
// - Slow 10 kHz and 32 kHz sources keep running.
// - Peripheral clocks survive power-down only if slow-sourced.
// - Five sources: 32k, 12M, PLL, 22M, 10k.
// - PLL reference selectable: 12M crystal or 22M.
// - System clock chosen by select register bits 2:0.
// - Tick clock chosen by select register bits 5:3.
// - Sixteen halving stages, one tap to pin.
// - Output equals input over two to N+1.
// - Enable rising edge resets then starts chain.
// - Disable runs chain until output low, holds.
`timescale 1ns/1ps
module cgp_clock_ctrl (
  input logic aclk,
  input logic aresetn,
  input logic ce,
  // AXI4-Lite slave
  input logic [cgp_pkg::AW-1:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [cgp_pkg::AW-1:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  // Raw source clocks from pads and analog macros
  input logic xtl32k_clk,
  input logic xtl12m_clk,
  input logic pll_clk,
  input logic osc10k_clk,
  input logic osc22m_clk,
  // Core handshake
  input logic core_sleep,
  input logic core_wake,
  output logic core_resume,
  // Source controls
  output logic xtl12m_en,
  output logic xtl32k_en,
  output logic osc22m_en,
  output logic osc10k_en,
  output logic pll_en,
  output logic pll_ref_sel,
  output logic power_down,
  // Generated clocks
  output logic sys_clk,
  output logic tick_timer_clock,
  output logic [cgp_pkg::NPER-1:0] periph_clk,
  output logic divider_output_pin
);
  import cgp_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [2:0] {
    PM_RUN, PM_GATE, PM_DOWN, PM_SETTLE, PM_RESUME
  } cgp_pm_type;

  typedef struct packed {
    logic aw_rdy;
    logic w_rdy;
    logic aw_have;
    logic w_have;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic b_valid;
    logic [1:0] b_resp;
    logic ar_rdy;
    logic r_valid;
    logic [31:0] r_data;
    logic [1:0] r_resp;
    logic [7:0] pwr;
    logic [5:0] sel0;
    logic [7:0] pen;
    logic [23:0] psel;
    logic [3:0] div_tap;
    logic div_en;
    cgp_pm_type pm;
    logic armed;
    logic [8:0] settle;
    logic resume;
    logic [5:0] osc_out;
    logic pd_out;
    logic div_src;
    logic div_run;
    logic div_stop;
    logic [15:0] div_cnt;
    logic div_pin;
  } cgp_state_type;

  cgp_state_type q;
  cgp_state_type d;

  logic [NSRC-1:0] src_raw;
  logic [NSRC-1:0] src_lvl;
  logic [NMUX-1:0][2:0] mux_sel;
  logic [NMUX-1:0] mux_gate;
  logic [NMUX-1:0] mux_out;
  logic [NMUX-1:0] mux_busy;
  logic awake;

  // ****************************************************************
  // Source sampling and clock selectors
  // ****************************************************************
  always_comb begin
    src_raw = '0;
    src_raw[SRC_XTL12M] = xtl12m_clk;
    src_raw[SRC_XTL32K] = xtl32k_clk;
    src_raw[SRC_PLL] = pll_clk;
    src_raw[SRC_OSC10K] = osc10k_clk;
    src_raw[SRC_OSC22M] = osc22m_clk;
  end

  cgp_sync2 #(.W(NSRC)) u_src_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .din(src_raw),
    .dout(src_lvl)
  );

  // Slot 0 system, slot 1 tick, the rest peripherals
  assign awake = (q.pm == PM_RUN) || (q.pm == PM_RESUME);

  always_comb begin
    mux_sel = '0;
    mux_gate = '0;
    mux_sel[0] = norm_sel(q.sel0[SEL0_SYS_LSB +: 3]);
    mux_gate[0] = awake;
    mux_sel[1] = norm_sel(q.sel0[SEL0_TICK_LSB +: 3]);
    mux_gate[1] = awake || is_low_freq(mux_sel[1]);
    for (int k = 0; k < NPER; k++) begin
      mux_sel[k + 2] = norm_sel(q.psel[3 * k +: 3]);
      mux_gate[k + 2] = q.pen[k] &&
        (awake || is_low_freq(mux_sel[k + 2]));
    end
  end

  for (genvar g = 0; g < NMUX; g++) begin : g_mux
    cgp_glitch_mux u_mux (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .src(src_lvl),
      .sel(mux_sel[g]),
      .gate(mux_gate[g]),
      .clk_out(mux_out[g]),
      .busy(mux_busy[g])
    );
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8 * b +: 8] = nw[8 * b +: 8];
      end
    end
    merge = r;
  endfunction : merge

  always_comb begin
    logic [31:0] cur;
    logic [31:0] nw;
    logic hit;
    cur = '0;
    nw = '0;
    hit = 1'b0;
    d = q;
    d.resume = 1'b0;

    // Write channel: address and data taken in either order
    if (q.b_valid && s_axi_bready) begin
      d.b_valid = 1'b0;
    end
    if (q.aw_rdy && s_axi_awvalid) begin
      d.aw_have = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (q.w_rdy && s_axi_wvalid) begin
      d.w_have = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    if (d.aw_have && d.w_have && !q.b_valid) begin
      hit = 1'b1;
      case ({d.aw_addr[7:2], 2'b00})
        OFS_PWR_CTRL: cur = {24'h0, q.pwr};
        OFS_SEL0: cur = {26'h0, q.sel0};
        OFS_PCLK_EN: cur = {24'h0, q.pen};
        OFS_PCLK_SEL: cur = {8'h0, q.psel};
        OFS_DIV_CTRL: cur = {27'h0, q.div_en, q.div_tap};
        OFS_STATUS: cur = '0;
        default: hit = 1'b0;
      endcase
      nw = merge(cur, d.w_data, d.w_strb);
      case ({d.aw_addr[7:2], 2'b00})
        OFS_PWR_CTRL: d.pwr = {nw[7], 1'b0, nw[5:0]};
        OFS_SEL0: d.sel0 = nw[5:0];
        OFS_PCLK_EN: d.pen = nw[7:0];
        OFS_PCLK_SEL: d.psel = nw[23:0];
        OFS_DIV_CTRL: begin
          d.div_tap = nw[DIV_TAP_LSB +: 4];
          d.div_en = nw[DIV_EN_BIT];
        end
        default: d.b_resp = RESP_OKAY;
      endcase
      d.b_resp = hit ? RESP_OKAY : RESP_SLVERR;
      d.b_valid = 1'b1;
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
    end
    d.aw_rdy = !d.aw_have && !d.b_valid;
    d.w_rdy = !d.w_have && !d.b_valid;

    // Read channel
    if (q.r_valid && s_axi_rready) begin
      d.r_valid = 1'b0;
    end
    if (q.ar_rdy && s_axi_arvalid) begin
      d.r_valid = 1'b1;
      d.r_resp = RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        OFS_PWR_CTRL: d.r_data = {24'h0, q.pwr};
        OFS_SEL0: d.r_data = {26'h0, q.sel0};
        OFS_PCLK_EN: d.r_data = {24'h0, q.pen};
        OFS_PCLK_SEL: d.r_data = {8'h0, q.psel};
        OFS_DIV_CTRL: d.r_data = {27'h0, q.div_en, q.div_tap};
        OFS_STATUS: d.r_data = {26'h0, q.armed, q.div_run,
                                mux_busy[1], mux_busy[0],
                                (q.pm == PM_SETTLE), q.pd_out};
        default: begin
          d.r_data = '0;
          d.r_resp = RESP_SLVERR;
        end
      endcase
    end
    d.ar_rdy = !d.r_valid;

    // Power-down sequencer
    if (!core_sleep) begin
      d.armed = 1'b1;
    end
    case (q.pm)
      PM_RUN: begin
        if (q.pwr[PWR_PD_EN] && core_sleep && q.armed) begin
          d.pm = PM_GATE;
          d.armed = 1'b0;
        end
      end
      PM_GATE: begin
        // Fast sources stop only after every closed gate has parked
        if (core_wake) begin
          d.pm = PM_RUN;
        end else if (&(mux_busy | mux_gate)) begin
          d.pm = PM_DOWN;
        end
      end
      PM_DOWN: begin
        if (core_wake) begin
          d.pm = PM_SETTLE;
          d.settle = '0;
        end
      end
      PM_SETTLE: begin
        d.settle = q.settle + 9'h1;
        if (q.settle == SETTLE_LAST) begin
          d.pm = PM_RESUME;
        end
      end
      PM_RESUME: begin
        // Core released only once the system clock is toggling again
        if (!mux_busy[0]) begin
          d.pm = PM_RUN;
          d.resume = 1'b1;
        end
      end
      default: d.pm = PM_RUN;
    endcase
    d.pd_out = (d.pm == PM_DOWN);
    d.osc_out[0] = q.pwr[PWR_XTL12M] && !d.pd_out;
    d.osc_out[1] = q.pwr[PWR_XTL32K];
    d.osc_out[2] = q.pwr[PWR_OSC22M] && !d.pd_out;
    d.osc_out[3] = q.pwr[PWR_OSC10K];
    d.osc_out[4] = q.pwr[PWR_PLL_EN] && !d.pd_out;
    d.osc_out[5] = q.pwr[PWR_PLL_REF];

    // Divider output, fed from the selected system clock
    d.div_src = mux_out[0];
    if (d.div_en && !q.div_en) begin
      d.div_run = 1'b1;
      d.div_stop = 1'b0;
      d.div_cnt = '0;
    end else begin
      if (!d.div_en && q.div_en) begin
        d.div_stop = 1'b1;
      end
      if (q.div_run && mux_out[0] && !q.div_src) begin
        d.div_cnt = q.div_cnt + 16'h1;
      end
      if (q.div_run && d.div_stop && !d.div_cnt[q.div_tap]) begin
        d.div_run = 1'b0;
        d.div_stop = 1'b0;
      end
    end
    d.div_pin = d.div_run && d.div_cnt[d.div_tap];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.pwr <= RST_PWR_CTRL;
      q.sel0 <= RST_SEL0;
      q.pen <= RST_PCLK_EN;
      q.psel <= RST_PCLK_SEL;
      q.div_tap <= RST_DIV_TAP;
      q.pm <= PM_RUN;
      q.aw_rdy <= 1'b1;
      q.w_rdy <= 1'b1;
      q.ar_rdy <= 1'b1;
      q.osc_out <= {RST_PWR_CTRL[PWR_PLL_REF], RST_PWR_CTRL[PWR_PLL_EN],
                    RST_PWR_CTRL[PWR_OSC10K], RST_PWR_CTRL[PWR_OSC22M],
                    RST_PWR_CTRL[PWR_XTL32K], RST_PWR_CTRL[PWR_XTL12M]};
    end else if (ce) begin
      q <= d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign s_axi_awready = q.aw_rdy;
  assign s_axi_wready = q.w_rdy;
  assign s_axi_bvalid = q.b_valid;
  assign s_axi_bresp = q.b_resp;
  assign s_axi_arready = q.ar_rdy;
  assign s_axi_rvalid = q.r_valid;
  assign s_axi_rdata = q.r_data;
  assign s_axi_rresp = q.r_resp;
  assign core_resume = q.resume;
  assign xtl12m_en = q.osc_out[0];
  assign xtl32k_en = q.osc_out[1];
  assign osc22m_en = q.osc_out[2];
  assign osc10k_en = q.osc_out[3];
  assign pll_en = q.osc_out[4];
  assign pll_ref_sel = q.osc_out[5];
  assign power_down = q.pd_out;
  assign sys_clk = mux_out[0];
  assign tick_timer_clock = mux_out[1];
  assign periph_clk = mux_out[NMUX-1:2];
  assign divider_output_pin = q.div_pin;

  // ****************************************************************
  // Checks
  // ****************************************************************
  pd_entry_a: assert property (@(posedge aclk)
    disable iff (!aresetn || !ce)
    (q.pm == PM_RUN) ##1 (q.pm == PM_GATE)
      |-> $past(core_sleep) && q.pwr[PWR_PD_EN])
    else $error("power-down entered without bit and sleep");
  hf_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.pm == PM_DOWN) |-> !xtl12m_en && !osc22m_en && !sys_clk)
    else $error("fast source or system clock alive in power-down");
  lf_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.pm == PM_DOWN) |-> (xtl32k_en == q.pwr[PWR_XTL32K]) &&
      (osc10k_en == q.pwr[PWR_OSC10K]))
    else $error("slow source stopped in power-down");
  for (genvar p = 2; p < NMUX; p++) begin : g_chk
    per_gate_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (q.pm == PM_DOWN && !is_low_freq(mux_sel[p])) |-> !mux_out[p])
      else $error("fast peripheral clock alive in power-down");
  end
  div_start_a: assert property (@(posedge aclk)
    disable iff (!aresetn || !ce)
    $rose(q.div_en) |-> q.div_run && (q.div_cnt == 16'h0) && !q.div_pin)
    else $error("divider not restarted on enable");
  div_tap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    q.div_run |-> (divider_output_pin == q.div_cnt[q.div_tap]))
    else $error("divider pin does not follow selected tap");
  div_halt_a: assert property (@(posedge aclk)
    disable iff (!aresetn || !ce)
    $fell(q.div_run) |-> !q.div_en && !divider_output_pin &&
      !q.div_cnt[q.div_tap])
    else $error("divider stopped with output high");
  wake_order_a: assert property (@(posedge aclk)
    disable iff (!aresetn || !ce)
    core_resume |-> ($past(q.pm) == PM_RESUME) && xtl12m_en == q.pwr[0])
    else $error("core resumed before clock restored");
  settle_hold_a: assert property (@(posedge aclk)
    disable iff (!aresetn || !ce)
    (q.pm == PM_SETTLE && q.settle != SETTLE_LAST) |=> (q.pm == PM_SETTLE))
    else $error("oscillator settle time cut short");
endmodule : cgp_clock_ctrl

/* File: rtl/cgp_glitch_mux.sv */
// Glitch-free clock selector with clean gating
`timescale 1ns/1ps
module cgp_glitch_mux (
  input logic aclk,
  input logic aresetn,
  input logic ce,
  input logic [cgp_pkg::NSRC-1:0] src,
  input logic [cgp_pkg::SELW-1:0] sel,
  input logic gate,
  output logic clk_out,
  output logic busy
);
  import cgp_pkg::*;

  typedef enum logic [0:0] {MX_FOLLOW, MX_PARK} cgp_mx_type;
  typedef struct packed {
    cgp_mx_type st;
    logic [2:0] cur;
    logic out;
  } cgp_mux_type;

  cgp_mux_type q;
  cgp_mux_type d;

  // Park only while both output and old source are low, resume only
  // on a low phase of the new source: no phase is ever shortened
  always_comb begin
    d = q;
    case (q.st)
      MX_FOLLOW: begin
        if (!q.out && !src[q.cur] && (sel != q.cur || !gate)) begin
          d.st = MX_PARK;
          d.out = 1'b0;
        end else begin
          d.out = src[q.cur];
        end
      end
      MX_PARK: begin
        d.out = 1'b0;
        d.cur = sel;
        if (gate && sel == q.cur && !src[q.cur]) begin
          d.st = MX_FOLLOW;
        end
      end
      default: begin
        d.st = MX_PARK;
        d.out = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '{st: MX_PARK, cur: SRC_OSC22M, out: 1'b0};
    end else if (ce) begin
      q <= d;
    end
  end

  assign clk_out = q.out;
  assign busy = (q.st == MX_PARK);

  park_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.st == MX_PARK) |-> !q.out)
    else $error("clock output high while parked");
  rise_follow_a: assert property (@(posedge aclk)
    disable iff (!aresetn || !ce)
    $rose(q.out) |-> ($past(q.st) == MX_FOLLOW) && (q.st == MX_FOLLOW))
    else $error("clock output rose outside follow state");
endmodule : cgp_glitch_mux

/* File: rtl/cgp_pkg.sv */
// Shared constants for the clock generator and power-down controller
package cgp_pkg;

  // ****************************************************************
  // Sources and clock outputs
  // ****************************************************************
  localparam int unsigned NSRC = 5;
  localparam int unsigned NPER = 8;
  localparam int unsigned NMUX = 10;
  localparam int unsigned SELW = 3;
  localparam logic [2:0] SRC_XTL12M = 3'h0;
  localparam logic [2:0] SRC_XTL32K = 3'h1;
  localparam logic [2:0] SRC_PLL = 3'h2;
  localparam logic [2:0] SRC_OSC10K = 3'h3;
  localparam logic [2:0] SRC_OSC22M = 3'h4;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam int unsigned AW = 8;
  localparam logic [7:0] OFS_PWR_CTRL = 8'h00;
  localparam logic [7:0] OFS_SEL0 = 8'h04;
  localparam logic [7:0] OFS_PCLK_EN = 8'h08;
  localparam logic [7:0] OFS_PCLK_SEL = 8'h0c;
  localparam logic [7:0] OFS_DIV_CTRL = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // Power control, clock select and divider fields
  localparam int unsigned PWR_XTL12M = 0;
  localparam int unsigned PWR_XTL32K = 1;
  localparam int unsigned PWR_OSC22M = 2;
  localparam int unsigned PWR_OSC10K = 3;
  localparam int unsigned PWR_PLL_EN = 4;
  localparam int unsigned PWR_PLL_REF = 5;
  localparam int unsigned PWR_PD_EN = 7;
  localparam int unsigned SEL0_SYS_LSB = 0;
  localparam int unsigned SEL0_TICK_LSB = 3;
  localparam int unsigned DIV_TAP_LSB = 0;
  localparam int unsigned DIV_EN_BIT = 4;

  // Reset values
  localparam logic [7:0] RST_PWR_CTRL = 8'h0c;
  localparam logic [5:0] RST_SEL0 = 6'h24;
  localparam logic [7:0] RST_PCLK_EN = 8'h00;
  localparam logic [23:0] RST_PCLK_SEL = 24'h924924;
  localparam logic [3:0] RST_DIV_TAP = 4'h0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned OSC_SETTLE_NS = 2000;
  localparam int unsigned SETTLE_CYC =
    (OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [8:0] SETTLE_LAST = 9'(SETTLE_CYC - 1);

  // Codes above the last source fall back to the internal oscillator
  function automatic logic [2:0] norm_sel(input logic [2:0] s);
    norm_sel = (s > SRC_OSC22M) ? SRC_OSC22M : s;
  endfunction : norm_sel

  function automatic logic is_low_freq(input logic [2:0] s);
    is_low_freq = (s == SRC_XTL32K) || (s == SRC_OSC10K);
  endfunction : is_low_freq

endpackage : cgp_pkg

/* File: rtl/cgp_sync2.sv */
// Two-stage synchroniser for asynchronous source levels
`timescale 1ns/1ps
module cgp_sync2 #(
  parameter int unsigned W = 1
) (
  input logic aclk,
  input logic aresetn,
  input logic ce,
  input logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } cgp_sync_type;

  cgp_sync_type q;
  cgp_sync_type d;

  always_comb begin
    d = q;
    d.meta = din;
    d.sync = q.meta;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign dout = q.sync;
endmodule : cgp_sync2

/* File: verification/cgp_clock_ctrl_tb.sv */
// Self-checking bench for the clock controller
`timescale 1ns/1ps
module cgp_clock_ctrl_tb;
  import cgp_pkg::*;
  logic aclk, aresetn, ce;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rd, rng;
  logic [1:0] bresp, rresp, resp;
  logic [3:0] wstrb;
  logic [4:0] src_clk;
  logic core_sleep, core_wake, core_resume, power_down;
  logic xtl12m_en, xtl32k_en, osc22m_en, osc10k_en, pll_en, pll_ref_sel;
  logic sys_clk, tick_clk, pin;
  logic [7:0] pclk;
  int err_total, comparisons;
  logic [7:0] ofs [5] = '{OFS_PWR_CTRL, OFS_SEL0, OFS_PCLK_EN,
    OFS_PCLK_SEL, OFS_DIV_CTRL};
  logic [31:0] rstv [5] = '{32'(RST_PWR_CTRL), 32'(RST_SEL0),
    32'(RST_PCLK_EN), 32'(RST_PCLK_SEL), 32'h00000000};

  cgp_src_model i_src (
    .en({osc22m_en, osc10k_en, pll_en, xtl32k_en, xtl12m_en}),
    .clk(src_clk)
  );

  cgp_clock_ctrl i_dut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .xtl32k_clk(src_clk[1]), .xtl12m_clk(src_clk[0]),
    .pll_clk(src_clk[2]), .osc10k_clk(src_clk[3]),
    .osc22m_clk(src_clk[4]), .core_sleep(core_sleep),
    .core_wake(core_wake), .core_resume(core_resume),
    .xtl12m_en(xtl12m_en), .xtl32k_en(xtl32k_en), .osc22m_en(osc22m_en),
    .osc10k_en(osc10k_en), .pll_en(pll_en), .pll_ref_sel(pll_ref_sel),
    .power_down(power_down), .sys_clk(sys_clk),
    .tick_timer_clock(tick_clk), .periph_clk(pclk),
    .divider_output_pin(pin)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  function automatic logic [31:0] div_span(input int n);
    return 32'h1 << (n + 1);
  endfunction : div_span

  // Opening edge keeps a release and a new request out of one time step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rdreg(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rdreg

  // System clock rises between two rises of the divider pin
  task automatic span(output int c);
    logic pp, sp;
    int edges;
    pp = pin;
    sp = sys_clk;
    c = 0;
    edges = 0;
    for (int k = 0; k < 3000 && edges < 2; k++) begin
      @(posedge aclk);
      if (edges == 1 && sys_clk && !sp) c++;
      if (pin && !pp) edges++;
      pp = pin;
      sp = sys_clk;
    end
  endtask : span

  task automatic report_and_stop;
    if (err_total == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  // ****************************************************************
  // Clock, watchdog and scenarios
  // ****************************************************************
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  initial begin
    #200000;
    err_total++;
    report_and_stop();
  end

  initial begin
    int n, c, a, b;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {core_sleep, core_wake, awaddr, araddr, wdata} = '0;
    ce = 1'b1;
    wstrb = 4'hf;
    rng = 32'h00017296;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rdreg(ofs[i]);
      chk("reset value", rd, rstv[i]);
    end
    rng = xs(rng);
    wr(8'h18, rng);
    chk("unmapped bresp", 32'(resp), 32'(RESP_SLVERR));
    rdreg(8'h18);
    chk("unmapped read", {rd[29:0], resp}, 32'(RESP_SLVERR));
    for (int i = 0; i < 6; i++) begin
      rng = xs(rng);
      wr(OFS_SEL0, rng);
      rdreg(OFS_SEL0);
      chk("select readback", rd, {26'h0, rng[5:0]});
    end
    wr(OFS_PWR_CTRL, 32'h3c);
    // Source enables follow the register one edge later
    @(posedge aclk);
    chk("pll reference", {pll_en, pll_ref_sel}, 2'b11);
    // Tick on the 32K crystal: 100 ns half period over 2000 ns
    wr(OFS_PWR_CTRL, 32'h0f);
    wr(OFS_SEL0, 32'h0c);
    repeat (50) @(posedge aclk);
    n = 0;
    for (int k = 0; k < 250; k++) begin
      a = tick_clk;
      @(posedge aclk);
      if (tick_clk != a) n++;
    end
    chk("tick rate", 32'(n >= 18 && n <= 22), 32'h1);
    // Clock enable low must freeze the selectors as well
    ce <= 1'b0;
    @(posedge aclk);
    a = tick_clk;
    n = 0;
    repeat (30) begin
      @(posedge aclk);
      if (tick_clk != a) n++;
    end
    ce <= 1'b1;
    chk("frozen tick", n, 0);
    wr(OFS_SEL0, 32'h24);
    for (int k = 0; k < 3; k++) begin
      rng = xs(rng);
      n = (k == 0) ? 0 : int'(rng % 3);
      wr(OFS_DIV_CTRL, 32'h10 | n);
      span(c);
      chk("divider span", c, div_span(n));
      wr(OFS_DIV_CTRL, 32'(n));
      for (int j = 0; j < 400 && pin; j++) @(posedge aclk);
      b = 0;
      repeat (100) begin
        @(posedge aclk);
        if (pin !== 1'b0) b++;
      end
      chk("divider parked", b, 0);
    end
    wr(OFS_PCLK_SEL, 32'h924921);
    wr(OFS_PCLK_EN, 32'h3);
    core_sleep <= 1'b1;
    repeat (40) @(posedge aclk);
    chk("sleep without bit", power_down, 1'b0);
    core_sleep <= 1'b0;
    wr(OFS_PWR_CTRL, 32'h8f);
    core_sleep <= 1'b1;
    for (int j = 0; j < 500 && !power_down; j++) @(posedge aclk);
    chk("power down entered", power_down, 1'b1);
    repeat (2) @(posedge aclk);
    chk("sources in power down", {xtl12m_en, osc22m_en, pll_en,
      osc10k_en, xtl32k_en}, 5'b00011);
    // Both selectors parked, power-down flag set, not armed
    rdreg(OFS_STATUS);
    chk("status in power down", rd, 32'h0000000d);
    a = 0;
    b = 0;
    n = 0;
    for (int k = 0; k < 200; k++) begin
      c = pclk[0];
      @(posedge aclk);
      if (sys_clk !== 1'b0) a++;
      if (pclk[1] !== 1'b0) b++;
      if (pclk[0] != c) n++;
    end
    chk("system clock stopped", a, 0);
    chk("fast peripheral stopped", b, 0);
    chk("slow peripheral runs", 32'(n > 4), 32'h1);
    core_wake <= 1'b1;
    @(posedge aclk);
    core_wake <= 1'b0;
    for (n = 0; n < 2000 && !core_resume; n++) @(posedge aclk);
    chk("resume seen", 32'(n < 2000), 32'h1);
    chk("awake sources", {osc22m_en, power_down}, 2'b10);
    core_sleep <= 1'b0;
    repeat (20) @(posedge aclk);
    report_and_stop();
  end
endmodule : cgp_clock_ctrl_tb

/* File: verification/cgp_src_model.sv */
// Behavioural oscillators and crystals feeding the clock controller
`timescale 1ns/1ps
module cgp_src_model (
  input wire logic [4:0] en,
  output logic [4:0] clk
);
  // ****************************************************************
  // Sources, indexed by the controller's source codes
  // ****************************************************************
  // Half periods in ns, all slower than a quarter of aclk, scaled down
  localparam int HALF [5] = '{40, 100, 20, 152, 24};

  for (genvar i = 0; i < 5; i++) begin : g_src
    initial begin
      clk[i] = 1'b0;
      forever begin
        #(HALF[i]);
        // A stopped source parks low instead of holding its last level
        clk[i] = en[i] ? ~clk[i] : 1'b0;
      end
    end
  end
endmodule : cgp_src_model
